// ### pkg/tls_pkg.sv
// Shared types and constants of the two-line serial port command handshake.
// Assumes a CPU-side clock domain and a separate link clock that paces the bus bits.
package tls_pkg;

  // Status codes shown on the status register; only meaningful while the done flag is set.
  localparam logic [7:0] ST_NONE = 8'hFF;
  localparam logic [7:0] ST_START_SENT = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK = 8'h20;
  localparam logic [7:0] ST_ADDR_NACK = 8'h24;
  localparam logic [7:0] ST_DATA_ACK = 8'h30;
  localparam logic [7:0] ST_DATA_NACK = 8'h34;

  // Reset values and bit-sequencing counts.
  localparam logic [7:0] SHIFT_DATA_RESET = 8'h00;
  localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  // CPU cycles for which reset is still held towards the link side after release.
  localparam logic [4:0] LINK_RESET_CYCLES = 5'h14;

  typedef enum logic [1:0] {
    TLS_OP_START,
    TLS_OP_BYTE,
    TLS_OP_STOP
  } tls_op_t;

  // One write to serial_control_reg.
  typedef struct packed {
    logic done_clear;
    logic start;
    logic stop;
    logic enable;
    logic done_irq_enable;
  } tls_ctrl_t;

  // Command handed from the CPU domain to the link domain.
  typedef struct packed {
    tls_op_t op;
    logic is_addr;
    logic [7:0] tx_byte;
  } tls_cmd_t;

  // Open-drain pin pair, enable high while the port pulls the line low.
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } tls_pins_t;

endpackage

// ### design/tls_sync.sv
// Two-flop synchroniser for levels and toggles entering a clock domain.
// Assumes the input changes no faster than the destination clock can sample it.
`timescale 1ns/1ps
module tls_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } tls_sync_state_t;

  tls_sync_state_t q;
  tls_sync_state_t next_q;

  // The first stage feeds the second stage only.
  always_comb begin
    next_q = q;
    next_q.stage1 = din;
    next_q.stage2 = q.stage1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign dout = q.stage2;

endmodule

// ### design/tls_port.sv
// Two-line serial port, master transmit path with its software command handshake.
// Assumes control bits arrive as plain ports from the CPU, and that link_clk runs free
// at four times the wanted bit rate. The bus lines are open drain with external pull-ups.
//
// Notes on behaviour
// - Done flag rises after every bus event except STOP.
// - Interrupt needs port and global enables both.
// - Writing one to done bit clears flag.
// - No new bus operation while flag set.
// - Clearing flag starts the commanded bus action.
// - START sent sets flag, start status code.
// - Address sent sets flag, code shows acknowledge.
// - Data sent sets flag, code shows acknowledge.
// - STOP finished leaves the done flag clear.
// - Clock line held low while flag set.
// - One shift register serves address and data.
// - Control write runs the operation its bits name; START wins over STOP.
// - Status shows bus state while flag set.
// - Status loads cycle after flag; otherwise none.
`timescale 1ns/1ps
module tls_port
  import tls_pkg::*;
(
  // CPU clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link clock
  input wire logic link_clk,
  // serial_control_reg write
  input wire logic ctrl_wr,
  input wire tls_ctrl_t ctrl_wdata,
  // serial_shift_data_reg write
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  // Global interrupt enable from cpu_status_reg
  input wire logic global_irq_en,
  // Status towards software
  output logic done_flag,
  output logic [7:0] serial_status_reg,
  output logic [7:0] serial_shift_data_reg,
  output logic busy,
  output logic irq_req,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  typedef struct packed {
    logic flag;
    logic [7:0] status;
    logic [7:0] ev_code;
    logic [7:0] shift_data;
    tls_cmd_t cmd;
    logic addr_next;
    logic enable;
    logic irq_en;
    logic req_tgl;
    logic ack_seen;
    logic busy;
    logic irq;
    logic [4:0] rst_cnt;
    logic link_rst_n;
  } tls_cpu_state_t;

  typedef enum logic {
    L_IDLE,
    L_RUN
  } tls_link_st_t;

  typedef struct packed {
    tls_link_st_t state;
    tls_op_t op;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    logic [7:0] shifter;
    logic nack;
    tls_pins_t pins;
    logic ack_tgl;
    logic req_seen;
  } tls_link_state_t;

  localparam tls_cpu_state_t CPU_RESET = '{
    flag: 1'b0,
    status: ST_NONE,
    ev_code: ST_NONE,
    shift_data: SHIFT_DATA_RESET,
    cmd: '{op: TLS_OP_START, is_addr: 1'b0, tx_byte: SHIFT_DATA_RESET},
    addr_next: 1'b0,
    enable: 1'b0,
    irq_en: 1'b0,
    req_tgl: 1'b0,
    ack_seen: 1'b0,
    busy: 1'b0,
    irq: 1'b0,
    rst_cnt: LINK_RESET_CYCLES,
    link_rst_n: 1'b0
  };

  localparam tls_link_state_t LINK_RESET = '{
    state: L_IDLE,
    op: TLS_OP_START,
    phase: 2'h0,
    bit_cnt: 4'h0,
    shifter: 8'h00,
    nack: 1'b0,
    pins: '{scl_oe: 1'b0, sda_oe: 1'b0},
    ack_tgl: 1'b0,
    req_seen: 1'b0
  };

  // Maps a finished operation and its acknowledge onto a status code.
  function automatic logic [7:0] event_code(input tls_op_t op, input logic is_addr, input logic nack);
    logic [7:0] code;
    code = ST_NONE;
    case (op)
      TLS_OP_START: begin
        code = ST_START_SENT;
      end
      TLS_OP_BYTE: begin
        if (is_addr) begin
          code = nack ? ST_ADDR_NACK : ST_ADDR_ACK;
        end else begin
          code = nack ? ST_DATA_NACK : ST_DATA_ACK;
        end
      end
      default: begin
        code = ST_NONE;
      end
    endcase
    return code;
  endfunction

  tls_cpu_state_t q;
  tls_cpu_state_t next_q;
  tls_link_state_t lq;
  tls_link_state_t next_lq;

  logic ack_sync;
  logic link_rst_n;
  logic req_sync;
  logic en_sync;
  logic scl_sync;
  logic sda_sync;
  logic pending;
  logic ack_new;

  // Crossings into the CPU domain. The answer path stays in reset until the link side has been reset,
  // so an undefined link state before its first reset edge never reaches the flag logic.
  tls_sync #(.W(1)) u_ack_sync (
    .clock(clock),
    .rst_n(q.link_rst_n),
    .din(lq.ack_tgl),
    .dout(ack_sync)
  );

  // The link domain has no reset of its own; a stretched copy of the CPU reset is carried over.
  // Limitation: a short CPU reset reaches the link only while its clock is at least a twentieth of the CPU clock.
  tls_sync #(.W(1)) u_rst_sync (
    .clock(link_clk),
    .rst_n(1'b1),
    .din(q.link_rst_n),
    .dout(link_rst_n)
  );

  tls_sync #(.W(4)) u_link_sync (
    .clock(link_clk),
    .rst_n(link_rst_n),
    .din({q.req_tgl, q.enable, scl_in, sda_in}),
    .dout({req_sync, en_sync, scl_sync, sda_sync})
  );

  // CPU domain: flag, status, command capture.
  always_comb begin
    next_q = q;
    pending = q.req_tgl != q.ack_seen;
    ack_new = ack_sync != q.ack_seen;
    next_q.ack_seen = ack_sync;
    if (q.rst_cnt != 5'h00) begin
      next_q.rst_cnt = q.rst_cnt - 5'h01;
    end
    next_q.link_rst_n = (q.rst_cnt == 5'h00);

    // Software may load the next byte at any time; the operation in flight uses its own copy.
    if (data_wr) begin
      next_q.shift_data = data_wdata;
    end

    if (ctrl_wr) begin
      next_q.enable = ctrl_wdata.enable;
      next_q.irq_en = ctrl_wdata.done_irq_enable;
      if (!ctrl_wdata.enable) begin
        next_q.flag = 1'b0;
        next_q.addr_next = 1'b0;
      end else if (ctrl_wdata.done_clear) begin
        next_q.flag = 1'b0;
        // A command is only taken when no operation is in flight, so a set flag never coexists with one.
        if (!pending) begin
          next_q.req_tgl = ~q.req_tgl;
          next_q.cmd.tx_byte = q.shift_data;
          next_q.cmd.is_addr = q.addr_next;
          if (ctrl_wdata.start) begin
            next_q.cmd.op = TLS_OP_START;
          end else if (ctrl_wdata.stop) begin
            next_q.cmd.op = TLS_OP_STOP;
          end else begin
            next_q.cmd.op = TLS_OP_BYTE;
          end
        end
      end
    end

    // A completion wins over a clear written in the same cycle.
    if (ack_new && q.enable && (q.cmd.op != TLS_OP_STOP)) begin
      next_q.flag = 1'b1;
      next_q.ev_code = event_code(q.cmd.op, q.cmd.is_addr, lq.nack);
      next_q.addr_next = q.cmd.op == TLS_OP_START;
    end else if (ack_new) begin
      next_q.addr_next = 1'b0;
    end

    next_q.status = q.flag ? q.ev_code : ST_NONE;
    next_q.irq = q.flag & q.irq_en & global_irq_en;
    next_q.busy = (next_q.req_tgl != ack_sync);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= CPU_RESET;
    end else begin
      q <= next_q;
    end
  end

  // Link domain: bit sequencer, four phases per bit.
  always_comb begin
    next_lq = lq;
    if (!en_sync) begin
      // Disabling releases the bus and answers any open request so the handshake stays paired.
      next_lq = LINK_RESET;
      next_lq.req_seen = req_sync;
      next_lq.ack_tgl = req_sync;
    end else begin
      case (lq.state)
        L_IDLE: begin
          if (req_sync != lq.req_seen) begin
            // The command is stable here because the CPU side holds it until the answer.
            next_lq.req_seen = req_sync;
            next_lq.op = q.cmd.op;
            next_lq.shifter = q.cmd.tx_byte;
            next_lq.nack = 1'b0;
            next_lq.phase = 2'h0;
            next_lq.bit_cnt = 4'h0;
            next_lq.state = L_RUN;
          end
        end
        L_RUN: begin
          next_lq.phase = lq.phase + 2'h1;
          case (lq.op)
            TLS_OP_START: begin
              case (lq.phase)
                2'h0: next_lq.pins.sda_oe = 1'b0;
                2'h1: next_lq.pins.scl_oe = 1'b0;
                2'h2: begin
                  if (scl_sync) begin
                    next_lq.pins.sda_oe = 1'b1;
                  end else begin
                    next_lq.phase = lq.phase;
                  end
                end
                default: begin
                  next_lq.pins.scl_oe = 1'b1;
                  next_lq.state = L_IDLE;
                  next_lq.ack_tgl = lq.req_seen;
                end
              endcase
            end
            TLS_OP_BYTE: begin
              case (lq.phase)
                2'h0: begin
                  if (lq.bit_cnt == ACK_BIT_INDEX) begin
                    next_lq.pins.sda_oe = 1'b0;
                  end else begin
                    next_lq.pins.sda_oe = ~lq.shifter[7];
                  end
                end
                2'h1: next_lq.pins.scl_oe = 1'b0;
                2'h2: begin
                  // A slave stretching the clock stalls the bit here.
                  if (!scl_sync) begin
                    next_lq.phase = lq.phase;
                  end else if (lq.bit_cnt == ACK_BIT_INDEX) begin
                    next_lq.nack = sda_sync;
                  end
                end
                default: begin
                  next_lq.pins.scl_oe = 1'b1;
                  next_lq.shifter = {lq.shifter[6:0], 1'b0};
                  if (lq.bit_cnt == ACK_BIT_INDEX) begin
                    next_lq.state = L_IDLE;
                    next_lq.ack_tgl = lq.req_seen;
                  end else begin
                    next_lq.bit_cnt = lq.bit_cnt + 4'h1;
                  end
                end
              endcase
            end
            default: begin
              case (lq.phase)
                2'h0: next_lq.pins.sda_oe = 1'b1;
                2'h1: next_lq.pins.scl_oe = 1'b0;
                2'h2: begin
                  if (scl_sync) begin
                    next_lq.pins.sda_oe = 1'b0;
                    next_lq.state = L_IDLE;
                    next_lq.ack_tgl = lq.req_seen;
                  end else begin
                    next_lq.phase = lq.phase;
                  end
                end
                default: begin
                  next_lq.phase = LAST_PHASE;
                end
              endcase
            end
          endcase
        end
        default: begin
          next_lq = LINK_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lq <= LINK_RESET;
    end else begin
      lq <= next_lq;
    end
  end

  assign done_flag = q.flag;
  assign serial_status_reg = q.status;
  assign serial_shift_data_reg = q.shift_data;
  assign busy = q.busy;
  assign irq_req = q.irq;
  assign scl_oe = lq.pins.scl_oe;
  assign sda_oe = lq.pins.sda_oe;
  // Open-drain lines: the port only ever pulls low.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

endmodule

// ### verif/tls_slave_model.sv
// Behavioural slave on the two bus lines; it acknowledges or refuses each byte.
// Assumes the bench resolves pulled-up lines from every pull-down enable.
`timescale 1ns/1ps
module tls_slave_model (
  // Resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // Behaviour select
  input wire logic nack,
  input wire logic stretch,
  // Pull-down enables and last byte seen
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] rx_byte
);
  int cnt = 0;
  logic [7:0] shreg = 8'h00;
  initial begin
    sda_pull = 1'b0;
    rx_byte = 8'h00;
  end
  // Stretching pulls the clock low whenever stretch is set, so setting it while the clock is high makes a falling edge of its own.
  assign scl_pull = stretch;
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      cnt = 0;
    end
  end
  always @(posedge scl) begin
    shreg = {shreg[6:0], sda};
    cnt = cnt + 1;
    if (cnt == 8) begin
      rx_byte = shreg;
    end
    if (cnt == 9) begin
      cnt = 0;
    end
  end
  always @(negedge scl) begin
    sda_pull = (cnt == 8) && !nack;
  end
endmodule

// ### verif/tls_port_sva.sv
// Assertions on the software handshake of tls_port.
// Sees only the ports of tls_port; all checks run on the CPU clock.
`timescale 1ns/1ps
module tls_port_sva
  import tls_pkg::*;
(
  // CPU side and link clock
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic ctrl_wr,
  input wire tls_ctrl_t ctrl_wdata,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic global_irq_en,
  input wire logic done_flag,
  input wire logic [7:0] serial_status_reg,
  input wire logic [7:0] serial_shift_data_reg,
  input wire logic busy,
  input wire logic irq_req,
  // Bus pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic clr_wr = ctrl_wr && ctrl_wdata.done_clear;
  flag_clear_a: assert property (clr_wr && done_flag && !busy |=> !done_flag) else $error("flag kept");
  zero_keep_a: assert property (ctrl_wr && ctrl_wdata.enable && !ctrl_wdata.done_clear && done_flag
    |=> done_flag) else $error("flag lost");
  no_new_op_a: assert property (done_flag && !clr_wr |=> !$rose(busy)) else $error("op while flag");
  cmd_go_a: assert property (clr_wr && ctrl_wdata.enable && !busy |=> busy) else $error("no start");
  op_bound_a: assert property ($rose(busy) |-> ##[1:1000] !busy) else $error("op hangs");
  flag_cause_a: assert property ($rose(done_flag) |-> $past(busy) || $past(busy, 2))
    else $error("flag without op");
  status_none_a: assert property (!done_flag |=> serial_status_reg == ST_NONE) else $error("stale status");
  status_valid_a: assert property (done_flag |=> serial_status_reg != ST_NONE) else $error("no status");
  scl_hold_a: assert property (done_flag [*2] |-> scl_oe) else $error("clock released");
  irq_gate_a: assert property (irq_req |-> $past(done_flag && global_irq_en)) else $error("bad irq");
  shift_load_a: assert property (data_wr |=> serial_shift_data_reg == $past(data_wdata))
    else $error("shift lost");
  cover property ($rose(done_flag));
  cover property (irq_req);
  cover property ($fell(busy) && !done_flag);
endmodule
bind tls_port tls_port_sva u_sva (.clock(clock), .rst_n(rst_n), .link_clk(link_clk), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .data_wr(data_wr), .data_wdata(data_wdata), .global_irq_en(global_irq_en),
  .done_flag(done_flag), .serial_status_reg(serial_status_reg), .serial_shift_data_reg(serial_shift_data_reg),
  .busy(busy), .irq_req(irq_req), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe));

// ### verif/tls_port_tb.sv
// Self-checking bench: one full write transfer of tls_port against a slave model.
// Assumes pulled-up bus lines and a free link clock unrelated to the CPU clock.
`timescale 1ns/1ps
module tls_port_tb
  import tls_pkg::*;
;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_wr = 1'b0;
  tls_ctrl_t ctrl_wdata = 5'h00;
  logic data_wr = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic global_irq_en = 1'b0;
  logic nack = 1'b0;
  logic stretch = 1'b0;
  logic done_flag, busy, irq_req, scl_oe, sda_oe, scl_pull, sda_pull, scl_lvl, sda_lvl;
  logic [7:0] status, shift_q, rx_byte;
  wire logic scl = !(scl_oe | scl_pull);
  wire logic sda = !(sda_oe | sda_pull);
  int n_errors = 0;
  int tests_run = 0;
  initial forever #5 clock = ~clock;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  tls_port u_dut (.clock(clock), .rst_n(rst_n), .link_clk(link_clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .data_wr(data_wr), .data_wdata(data_wdata), .global_irq_en(global_irq_en), .done_flag(done_flag),
    .serial_status_reg(status), .serial_shift_data_reg(shift_q), .busy(busy), .irq_req(irq_req),
    .scl_in(scl), .scl_out(scl_lvl), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_lvl), .sda_oe(sda_oe));
  tls_slave_model u_slave (.scl(scl), .sda(sda), .nack(nack), .stretch(stretch), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .rx_byte(rx_byte));
  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic ctrl(input logic clr, input logic sta, input logic sto, input logic en, input logic ie);
    step(1);
    ctrl_wr = 1'b1;
    ctrl_wdata = '{clr, sta, sto, en, ie};
    step(1);
    ctrl_wr = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] b);
    step(1);
    data_wr = 1'b1;
    data_wdata = b;
    step(1);
    data_wr = 1'b0;
  endtask
  // Waits for the flag to rise, or for busy to fall when want_flag is low.
  task automatic wait_on(input logic want_flag);
    int i;
    for (i = 0; i < 3000; i++) begin
      step(1);
      if (want_flag ? done_flag === 1'b1 : busy === 1'b0) break;
    end
    if (i == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  initial begin
    // Reset lasts three cycles; the port itself stretches it for the link side.
    step(3);
    rst_n = 1'b1;
    chk({5'h00, done_flag, busy, irq_req}, 8'h00);
    chk(status, ST_NONE);
    chk(shift_q, SHIFT_DATA_RESET);
    ctrl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    wait_on(1'b1);
    step(1);
    chk(status, ST_START_SENT);
    chk({7'h00, irq_req}, 8'h00);
    step(20);
    chk({7'h00, scl}, 8'h00);
    chk({6'h00, scl_lvl, sda_lvl}, 8'h00);
    ctrl(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    step(3);
    chk({6'h00, done_flag, busy}, 8'h02);
    chk(status, ST_START_SENT);
    put_byte(8'hA4);
    ctrl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_on(1'b1);
    step(1);
    chk(status, ST_ADDR_ACK);
    chk(rx_byte, 8'hA4);
    nack = 1'b1;
    global_irq_en = 1'b1;
    put_byte(8'h5B);
    ctrl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    put_byte(8'hC3);
    wait_on(1'b1);
    step(1);
    chk(status, ST_DATA_NACK);
    chk(rx_byte, 8'h5B);
    chk(shift_q, 8'hC3);
    chk({7'h00, irq_req}, 8'h01);
    global_irq_en = 1'b0;
    step(2);
    chk({7'h00, irq_req}, 8'h00);
    nack = 1'b0;
    put_byte(8'h96);
    stretch = 1'b1;
    ctrl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    step(60);
    stretch = 1'b0;
    wait_on(1'b1);
    step(1);
    chk(status, ST_DATA_ACK);
    chk(rx_byte, 8'h96);
    ctrl(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    step(1);
    wait_on(1'b0);
    step(30);
    chk({6'h00, done_flag, busy}, 8'h00);
    chk(status, ST_NONE);
    chk({6'h00, scl, sda}, 8'h03);
    ctrl(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    wait_on(1'b1);
    step(1);
    chk(status, ST_START_SENT);
    ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    step(30);
    chk({7'h00, done_flag}, 8'h00);
    chk({6'h00, scl, sda}, 8'h03);
    tally_and_finish();
  end
endmodule
